// ==== logic/flrm_pkg.sv ====
// Package of shared constants for the field line redundancy manager.
// Assumes a 10 MHz reference clock.
`default_nettype none
package flrm_pkg;
   // ***************************************************
   // Clock and timing
   // ***************************************************
   localparam int CLK_HZ = 10000000;
   localparam int DIG_SCAN_MS = 50;
   localparam int ANA_SCAN_MIN_MS = 425;
   localparam int ANA_SCAN_MAX_MS = 1700;
   localparam int SWAP_MS = 1000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int DIG_SCAN_CYC = DIG_SCAN_MS * CYC_PER_MS;
   localparam int ANA_SCAN_MIN_CYC = ANA_SCAN_MIN_MS * CYC_PER_MS;
   localparam int ANA_SCAN_MAX_CYC = ANA_SCAN_MAX_MS * CYC_PER_MS;
   localparam int SWAP_CYC = SWAP_MS * CYC_PER_MS;
   // ***************************************************
   // Sizes and reset values
   // ***************************************************
   localparam int RETRIES = 3;
   localparam int N_REP = 4;
   localparam int N_DIG = 4;
   localparam int REP_MAP_RST = 0;
   localparam int CNT_W = 32;
   typedef enum logic [1:0] {FLRM_NORMAL, FLRM_RETRY, FLRM_RECOVERY} flrm_state_t;
endpackage
`default_nettype wire

// ==== logic/flrm_timer.sv ====
// Free running cycle timer giving a one-cycle tick every PERIOD cycles.
// Assumes a single clock and synchronous clear.
`timescale 1ns/100ps
`default_nettype none
module flrm_timer #(
   parameter int PERIOD = 100
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clear_i,
   output logic tick_o
);
   logic [31:0] count;
   // ***************************************************
   // Counter
   // ***************************************************
   // Clear restarts the period
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count <= 32'h0;
         tick_o <= 1'b0;
      end else if (clear_i) begin
         count <= 32'h0;
         tick_o <= 1'b0;
      end else if (count == 32'(PERIOD - 1)) begin
         count <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         count <= count + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== logic/flrm_top.sv ====
// Field line redundancy manager: line choice, retry, recovery,
// repeater mapping and scan cadence ticks.
// Assumes the line engine reports one result per transaction.
// Function
// [R1] Single line: no recovery actions, only report the fault.
// [R2] Two healthy lines: alternate active line at fixed interval.
// [R3] On error start retries to check whether fault is transient.
// [R4] Persisting error after retries: declare that line broken.
// [R5] Recovery: use good line, stop alternating, raise error report.
// [R6] Leave recovery only on reactivation command or reset.
// [R7] Both repeater kinds alike; any repeater mapped to any digital unit.
// [R8] One digital unit may feed up to four repeaters at once.
// [R9] Mapping never hides input unit data from host side.
// [R10] Scan four digital units within one 50 ms cycle.
// [R11] Analog unit scan cycle within 425 to 1700 ms by configuration.
// [R12] Per-line fault flag held from failure until reactivation.
`timescale 1ns/100ps
`default_nettype none
module flrm_top #(
   parameter int SWAP_CYC = flrm_pkg::SWAP_CYC,
   parameter int DIG_SCAN_CYC = flrm_pkg::DIG_SCAN_CYC,
   parameter int ANA_SCAN_MIN_CYC = flrm_pkg::ANA_SCAN_MIN_CYC,
   parameter int ANA_SCAN_MAX_CYC = flrm_pkg::ANA_SCAN_MAX_CYC,
   parameter int RETRIES = flrm_pkg::RETRIES,
   parameter int DATA_W = 32
) (
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic DUAL_LINE_I,
   input wire logic XFER_DONE_I,
   input wire logic XFER_ERR_I,
   input wire logic REACTIVATE_I,
   input wire logic ANA_LONG_I,
   input wire logic [1:0] REP_SEL_I,
   input wire logic [1:0] REP_UNIT_I,
   input wire logic REP_WE_I,
   input wire logic [1:0] UNIT_SEL_I,
   input wire logic [DATA_W-1:0] UNIT_DATA_I,
   input wire logic UNIT_WE_I,
   input wire logic [1:0] HOST_SEL_I,
   output logic ACTIVE_LINE_O,
   output logic RETRY_O,
   output logic RECOVERY_O,
   output logic ERROR_O,
   output logic [1:0] LINE_FAULT_O,
   output logic DIG_SCAN_O,
   output logic ANA_SCAN_O,
   output logic [DATA_W-1:0] HOST_DATA_O,
   output logic [4*DATA_W-1:0] REP_DATA_O
);
   flrm_pkg::flrm_state_t state;
   logic [7:0] retry_cnt;
   logic swap_tick;
   logic dig_tick;
   logic ana_tick_s;
   logic ana_tick_l;
   logic [1:0] rep_map [flrm_pkg::N_REP];
   logic [DATA_W-1:0] unit_data [flrm_pkg::N_DIG];
   logic alt_run;

   // ***************************************************
   // Cadence timers
   // ***************************************************
   // Alternation only runs with two healthy lines in normal state
   assign alt_run = DUAL_LINE_I && (state == flrm_pkg::FLRM_NORMAL);
   flrm_timer #(.PERIOD(SWAP_CYC)) u_swap (
      .clk_i(REF_CLK_I),
      .reset_n_i(RESET_N_I),
      .clear_i(!alt_run),
      .tick_o(swap_tick)
   );
   flrm_timer #(.PERIOD(DIG_SCAN_CYC)) u_dig (
      .clk_i(REF_CLK_I),
      .reset_n_i(RESET_N_I),
      .clear_i(1'b0),
      .tick_o(dig_tick)
   );
   flrm_timer #(.PERIOD(ANA_SCAN_MIN_CYC)) u_ana_s (
      .clk_i(REF_CLK_I),
      .reset_n_i(RESET_N_I),
      .clear_i(ANA_LONG_I),
      .tick_o(ana_tick_s)
   );
   flrm_timer #(.PERIOD(ANA_SCAN_MAX_CYC)) u_ana_l (
      .clk_i(REF_CLK_I),
      .reset_n_i(RESET_N_I),
      .clear_i(!ANA_LONG_I),
      .tick_o(ana_tick_l)
   );

   // ***************************************************
   // Scan ticks
   // ***************************************************
   // Start of each scan cycle, one cycle wide
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         DIG_SCAN_O <= 1'b0;
         ANA_SCAN_O <= 1'b0;
      end else begin
         DIG_SCAN_O <= dig_tick; // [R10]
         ANA_SCAN_O <= ANA_LONG_I ? ana_tick_l : ana_tick_s; // [R11]
      end
   end

   // ***************************************************
   // Line state machine
   // ***************************************************
   // Reactivation is only acted on in recovery, where transfer errors are ignored
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state <= flrm_pkg::FLRM_NORMAL;
         retry_cnt <= 8'h0;
      end else begin
         unique case (state)
            flrm_pkg::FLRM_NORMAL: begin
               retry_cnt <= 8'h0;
               if (XFER_ERR_I) begin
                  state <= flrm_pkg::FLRM_RETRY; // [R3]
               end
            end
            flrm_pkg::FLRM_RETRY: begin
               if (XFER_DONE_I && !XFER_ERR_I) begin
                  state <= flrm_pkg::FLRM_NORMAL;
               end else if (XFER_ERR_I) begin
                  if (retry_cnt == 8'(RETRIES - 1)) begin
                     state <= flrm_pkg::FLRM_RECOVERY; // [R4]
                  end else begin
                     retry_cnt <= retry_cnt + 8'h1;
                  end
               end
            end
            flrm_pkg::FLRM_RECOVERY: begin
               if (REACTIVATE_I) begin
                  state <= flrm_pkg::FLRM_NORMAL; // [R6]
               end
            end
         endcase
      end
   end

   // ***************************************************
   // Active line and fault flags
   // ***************************************************
   // Single line keeps line 0 and only reports the fault
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ACTIVE_LINE_O <= 1'b0;
      end else if (!DUAL_LINE_I) begin
         ACTIVE_LINE_O <= 1'b0; // [R1]
      end else if (state == flrm_pkg::FLRM_RETRY && XFER_ERR_I && retry_cnt == 8'(RETRIES - 1)) begin
         ACTIVE_LINE_O <= !ACTIVE_LINE_O; // [R5]
      end else if (swap_tick && alt_run) begin
         ACTIVE_LINE_O <= !ACTIVE_LINE_O; // [R2]
      end
   end

   // Fault flag set wins over a reactivation in the same cycle
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         LINE_FAULT_O <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (state == flrm_pkg::FLRM_RETRY && XFER_ERR_I && retry_cnt == 8'(RETRIES - 1)
                && ACTIVE_LINE_O == 1'(i)) begin
               LINE_FAULT_O[i] <= 1'b1; // [R12]
            end else if (REACTIVATE_I) begin
               LINE_FAULT_O[i] <= 1'b0; // [R12]
            end
         end
      end
   end

   // Status outputs registered from state
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RETRY_O <= 1'b0;
         RECOVERY_O <= 1'b0;
         ERROR_O <= 1'b0;
      end else begin
         RETRY_O <= (state == flrm_pkg::FLRM_RETRY);
         RECOVERY_O <= (state == flrm_pkg::FLRM_RECOVERY) && DUAL_LINE_I; // [R5]
         ERROR_O <= (state == flrm_pkg::FLRM_RECOVERY); // [R1] [R5]
      end
   end

   // ***************************************************
   // Repeater mapping and unit data
   // ***************************************************
   // Any repeater to any unit; several repeaters may share one unit
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int r = 0; r < flrm_pkg::N_REP; r++) begin
            rep_map[r] <= 2'(flrm_pkg::REP_MAP_RST);
         end
      end else if (REP_WE_I) begin
         rep_map[REP_SEL_I] <= REP_UNIT_I; // [R7] [R8]
      end
   end

   // Latest status of each digital unit
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int u = 0; u < flrm_pkg::N_DIG; u++) begin
            unit_data[u] <= '0;
         end
      end else if (UNIT_WE_I) begin
         unit_data[UNIT_SEL_I] <= UNIT_DATA_I;
      end
   end

   // Host read path ignores the mapping entirely
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         HOST_DATA_O <= '0;
         REP_DATA_O <= '0;
      end else begin
         HOST_DATA_O <= unit_data[HOST_SEL_I]; // [R9]
         for (int r = 0; r < flrm_pkg::N_REP; r++) begin
            REP_DATA_O[r*DATA_W +: DATA_W] <= unit_data[rep_map[r]]; // [R7] [R8]
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/flrm_field_model.sv ====
// Far-side model: remote field units answering on the active line.
// Assumes one request pulse per transaction from the bench.
`timescale 1ns/100ps
`default_nettype none
module flrm_field_model (
   input wire logic clk_i,
   input wire logic active_line_i,
   input wire logic req_i,
   input wire logic [1:0] bad_i,
   output logic done_o,
   output logic err_o
);
   // One answer per request cycle; a broken line always fails
   always @(posedge clk_i) begin
      done_o <= req_i;
      err_o <= req_i & bad_i[active_line_i];
   end
endmodule
`default_nettype wire

// ==== verification/flrm_top_assertions.sv ====
// Checker of line failover and scan cadence at the flrm_top ports.
// Assumes the bind below and a single clock domain.
`timescale 1ns/100ps
`default_nettype none
module flrm_checker #(
   parameter int DIG_SCAN_CYC = 10,
   parameter int ANA_SCAN_MIN_CYC = 15,
   parameter int ANA_SCAN_MAX_CYC = 30
) (
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   input wire logic DUAL_LINE_I,
   input wire logic XFER_ERR_I,
   input wire logic REACTIVATE_I,
   input wire logic ANA_LONG_I,
   input wire logic ACTIVE_LINE_O,
   input wire logic RETRY_O,
   input wire logic RECOVERY_O,
   input wire logic ERROR_O,
   input wire logic [1:0] LINE_FAULT_O,
   input wire logic DIG_SCAN_O,
   input wire logic ANA_SCAN_O
);
   // *****
   // Properties
   // *****
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   chk_single_no_recovery: assert property (!DUAL_LINE_I |-> !RECOVERY_O) else $error("recovery on one line");
   chk_single_no_swap: assert property (!DUAL_LINE_I |-> $stable(ACTIVE_LINE_O)) else $error("swap on one line");
   chk_retry_cause: assert property ($rose(RETRY_O) |-> $past(XFER_ERR_I, 2)) else $error("retry without error");
   chk_broken_cause: assert property ($rose(ERROR_O) |-> $past(XFER_ERR_I, 2) && $past(RETRY_O))
      else $error("error report without retries");
   chk_failover_flip: assert property ($rose(RECOVERY_O) |-> $past(ACTIVE_LINE_O) != $past(ACTIVE_LINE_O, 2))
      else $error("no move to good line");
   chk_recovery_hold: assert property (RECOVERY_O && $past(RECOVERY_O) |-> $stable(ACTIVE_LINE_O))
      else $error("swap in recovery");
   chk_recovery_error: assert property (RECOVERY_O |-> ERROR_O) else $error("recovery without error");
   chk_leave_on_command: assert property ($fell(ERROR_O) |-> $past(REACTIVATE_I, 2))
      else $error("error report left without command");
   chk_fault_sticky: assert property (|($past(LINE_FAULT_O) & ~LINE_FAULT_O) |-> $past(REACTIVATE_I))
      else $error("fault cleared without command");
   chk_dig_period: assert property (DIG_SCAN_O |=> !DIG_SCAN_O ##(DIG_SCAN_CYC-1) DIG_SCAN_O)
      else $error("digital scan period");
   chk_ana_short: assert property (ANA_SCAN_O && !ANA_LONG_I |=> !ANA_SCAN_O ##(ANA_SCAN_MIN_CYC-1) ANA_SCAN_O)
      else $error("short analog period");
   chk_ana_long: assert property (ANA_SCAN_O && ANA_LONG_I |=> !ANA_SCAN_O ##(ANA_SCAN_MAX_CYC-1) ANA_SCAN_O)
      else $error("long analog period");
endmodule
bind flrm_top flrm_checker #(.DIG_SCAN_CYC(DIG_SCAN_CYC), .ANA_SCAN_MIN_CYC(ANA_SCAN_MIN_CYC),
   .ANA_SCAN_MAX_CYC(ANA_SCAN_MAX_CYC)) u_chk (.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
   .DUAL_LINE_I(DUAL_LINE_I), .XFER_ERR_I(XFER_ERR_I), .REACTIVATE_I(REACTIVATE_I), .ANA_LONG_I(ANA_LONG_I),
   .ACTIVE_LINE_O(ACTIVE_LINE_O), .RETRY_O(RETRY_O), .RECOVERY_O(RECOVERY_O), .ERROR_O(ERROR_O),
   .LINE_FAULT_O(LINE_FAULT_O), .DIG_SCAN_O(DIG_SCAN_O), .ANA_SCAN_O(ANA_SCAN_O));
`default_nettype wire

// ==== verification/tb_top.sv ====
// Testbench of flrm_top: failover, mapping and scan cadence.
// Assumes the field model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, dual = 1'b1, req = 1'b0, react = 1'b0, along = 1'b0;
   logic rep_we = 1'b0, unit_we = 1'b0, done, xerr, act, retry, recov, erro, dscan, ascan;
   logic [1:0] rep_sel = 2'h0, rep_unit = 2'h0, unit_sel = 2'h0, host_sel = 2'h0, bad = 2'h0, fault;
   logic [31:0] unit_data = 32'h0, hdata;
   logic [127:0] rdata;
   int bad_count = 0, num_checks = 0, kd, ka;
   // *****
   // Clock, model and design; short counts keep the run brief
   // *****
   always #50 clk = ~clk;
   flrm_field_model model (.clk_i(clk), .active_line_i(act), .req_i(req), .bad_i(bad), .done_o(done), .err_o(xerr));
   flrm_top #(.SWAP_CYC(20), .DIG_SCAN_CYC(10), .ANA_SCAN_MIN_CYC(15), .ANA_SCAN_MAX_CYC(30)) dut (
      .REF_CLK_I(clk), .RESET_N_I(rst_n), .DUAL_LINE_I(dual), .XFER_DONE_I(done), .XFER_ERR_I(xerr),
      .REACTIVATE_I(react), .ANA_LONG_I(along), .REP_SEL_I(rep_sel), .REP_UNIT_I(rep_unit), .REP_WE_I(rep_we),
      .UNIT_SEL_I(unit_sel), .UNIT_DATA_I(unit_data), .UNIT_WE_I(unit_we), .HOST_SEL_I(host_sel),
      .ACTIVE_LINE_O(act), .RETRY_O(retry), .RECOVERY_O(recov), .ERROR_O(erro), .LINE_FAULT_O(fault),
      .DIG_SCAN_O(dscan), .ANA_SCAN_O(ascan), .HOST_DATA_O(hdata), .REP_DATA_O(rdata));
   // *****
   // Shared tasks
   // *****
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic rst(input logic d, input logic a);
      rst_n = 1'b0;
      dual = d;
      along = a;
      cyc(4);
      rst_n = 1'b1;
   endtask
   task automatic xfer(input int n, input logic [1:0] b);
      bad = b;
      req = 1'b1;
      cyc(n);
      req = 1'b0;
   endtask
   task automatic reactivate();
      react = 1'b1;
      cyc(1);
      react = 1'b0;
      cyc(3);
   endtask
   function automatic logic [31:0] val(input int i);
      return 32'h1111_1111 * (i + 1);
   endfunction
   task automatic conclude();
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // *****
   // Scenarios
   // *****
   task automatic t_fail();
      rst(1'b1, 1'b0);
      xfer(4, 2'h3);
      cyc(3);
      chk({recov, erro, fault, act}, 5'h1b);
      cyc(30);
      xfer(2, 2'h3);
      cyc(3);
      chk({recov, erro, fault, act}, 5'h1b);
      reactivate();
      chk({recov, erro, fault, retry, act}, 6'h01);
      cyc(20);
      chk(act, 1'b0);
   endtask
   task automatic t_transient();
      rst(1'b1, 1'b0);
      xfer(1, 2'h3);
      cyc(2);
      chk(retry, 1'b1);
      xfer(1, 2'h0);
      cyc(3);
      chk({retry, erro, fault}, 4'h0);
   endtask
   task automatic t_single();
      rst(1'b0, 1'b0);
      cyc(30);
      xfer(4, 2'h3);
      cyc(3);
      chk({recov, erro, act}, 3'h2);
      reactivate();
      chk(erro, 1'b0);
   endtask
   task automatic t_map();
      unit_we = 1'b1;
      for (int i = 0; i < 4; i++) begin
         unit_sel = i[1:0];
         unit_data = val(i);
         cyc(1);
      end
      unit_we = 1'b0;
      cyc(2);
      chk(rdata, {4{val(0)}});
      rep_we = 1'b1;
      for (int r = 0; r < 4; r++) begin
         rep_sel = r[1:0];
         rep_unit = 2'h2;
         cyc(1);
      end
      rep_we = 1'b0;
      cyc(2);
      chk(rdata, {4{val(2)}});
      rep_we = 1'b1;
      for (int r = 0; r < 4; r++) begin
         rep_sel = r[1:0];
         rep_unit = 2'(3 - r);
         cyc(1);
      end
      rep_we = 1'b0;
      cyc(2);
      chk(rdata, {val(0), val(1), val(2), val(3)});
      for (int i = 0; i < 4; i++) begin
         host_sel = i[1:0];
         cyc(2);
         chk(hdata, val(i));
      end
   endtask
   task automatic t_scan(input logic a, input int expa);
      rst(1'b1, a);
      kd = 0;
      ka = 0;
      // First pulse lands one full period plus the output register after release
      repeat (61) begin
         @(posedge clk);
         #1;
         if (dscan === 1'b1) kd++;
         if (ascan === 1'b1) ka++;
      end
      cyc(1);
      chk(kd, 6);
      chk(ka, expa);
   endtask
   // Main sequence and watchdog share the one closing task
   initial begin
      t_fail();
      t_transient();
      t_single();
      t_map();
      t_scan(1'b0, 4);
      t_scan(1'b1, 2);
      conclude();
   end
   initial begin
      cyc(5000);
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
